// file: verilog/acrf_defines.svh
`ifndef ACRF_DEFINES_SVH
`define ACRF_DEFINES_SVH

// ----------------------------------------------------------------------------
// Widths and channel count
// ----------------------------------------------------------------------------
`define ACRF_CHANNELS 2
`define ACRF_DIFF_W 24
`define ACRF_CM_W 8
`define ACRF_GAIN_W 16
`define ACRF_GAIN_FRAC 15
`define ACRF_WORD_W 32
`define ACRF_BITS_W 6
`define ACRF_COUNT_W 8

// ----------------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------------
`define ACRF_DIFF_MAX 24'h7fffff
`define ACRF_DIFF_MIN 24'h800000
`define ACRF_OFFSET_RESET 24'h000000
`define ACRF_GAIN_UNITY 16'h8000
`define ACRF_FMT_W 3
`define ACRF_FMT_DIFF24 3'h0
`define ACRF_FMT_DIFF16_CM 3'h1
`define ACRF_FMT_DIFF24_CM 3'h2
`define ACRF_BITS_24 6'h18
`define ACRF_BITS_32 6'h20

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define ACRF_CLK_PERIOD_NS 100
`define ACRF_CONV_TIME_NS 500
`define ACRF_CONV_CYCLES ((`ACRF_CONV_TIME_NS + `ACRF_CLK_PERIOD_NS - 1) / `ACRF_CLK_PERIOD_NS)

`endif

// file: verilog/acrf_pkg.sv
`include "acrf_defines.svh"

package acrf_pkg;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ACRF_IDLE = 2'b01,
    ACRF_CONV = 2'b10
  } acrf_state_t;

  typedef struct packed {
    logic over_pos;
    logic over_neg;
    logic [`ACRF_DIFF_W-1:0] diff;
    logic [`ACRF_CM_W-1:0] cm;
  } acrf_raw_t;

  typedef struct packed {
    logic [`ACRF_WORD_W-1:0] data;
    logic [`ACRF_BITS_W-1:0] bits;
  } acrf_word_t;

  typedef struct packed {
    acrf_state_t phase;
    logic pin_prev;
    logic [`ACRF_COUNT_W-1:0] count;
    acrf_raw_t [`ACRF_CHANNELS-1:0] held;
  } acrf_ctl_t;

  typedef struct packed {
    logic valid;
    acrf_word_t [`ACRF_CHANNELS-1:0] word;
  } acrf_out_t;

endpackage : acrf_pkg

// file: verilog/acrf_scale.sv
`include "acrf_defines.svh"

module acrf_scale #(
  parameter int DW = `ACRF_DIFF_W,
  parameter int GW = `ACRF_GAIN_W,
  parameter int FRAC = `ACRF_GAIN_FRAC
) (
  input wire logic signed [DW-1:0] raw_code,
  input wire logic over_pos,
  input wire logic over_neg,
  input wire logic signed [DW-1:0] offset,
  input wire logic [GW-1:0] gain,
  output logic signed [DW-1:0] scaled
);
  localparam int PW = DW + GW + 2;
  localparam logic signed [DW-1:0] MAX_D = {1'b0, {(DW-1){1'b1}}};
  localparam logic signed [DW-1:0] MIN_D = {1'b1, {(DW-1){1'b0}}};
  localparam logic signed [PW-1:0] MAX_W = {{(PW-DW+1){1'b0}}, {(DW-1){1'b1}}};
  localparam logic signed [PW-1:0] MIN_W = {{(PW-DW+1){1'b1}}, {(DW-1){1'b0}}};

  logic signed [DW-1:0] clamped;
  logic signed [DW:0] sum;
  logic signed [PW-1:0] prod;
  logic signed [PW-1:0] shifted;

  always_comb begin
    // Out-of-range inputs force full scale before any adjustment.
    if (over_pos) begin
      clamped = MAX_D;
    end else if (over_neg) begin
      clamped = MIN_D;
    end else begin
      clamped = raw_code;
    end
    sum = {clamped[DW-1], clamped} + {offset[DW-1], offset};
    prod = sum * $signed({1'b0, gain});
    shifted = prod >>> FRAC;
    if (shifted > MAX_W) begin
      scaled = MAX_D;
    end else if (shifted < MIN_W) begin
      scaled = MIN_D;
    end else begin
      scaled = shifted[DW-1:0];
    end
  end
endmodule // acrf_scale

// file: verilog/acrf_result_reg.sv
`include "acrf_defines.svh"

module acrf_result_reg (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire acrf_pkg::acrf_word_t [`ACRF_CHANNELS-1:0] din,
  output acrf_pkg::acrf_word_t [`ACRF_CHANNELS-1:0] dout,
  output logic valid
);
  import acrf_pkg::*;

  acrf_out_t st;
  acrf_out_t next_st;

  // --------------------------------------------------------------------------
  // Output register: the word changes only on a load and holds otherwise; valid is high for the cycle after each load
  // --------------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.valid = load;
    if (load) begin
      next_st.word = din;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.word;
  assign valid = st.valid;
endmodule // acrf_result_reg

// file: verilog/acrf_formatter.sv
`include "acrf_defines.svh"

// What this block does
// - A rising edge on the convert-start pin starts a conversion of held samples.
// - Busy rises on that edge, stays high during conversion, falls when done.
// - Each conversion gives a 24-bit difference code and an 8-bit common-mode code.
// - The result is optionally post-processed, then latched into the output register.
// - No pipeline latency: the result belongs to the conversion just finished.
// - The first conversion after power-down already yields a valid result.
// - Difference codes are twos complement; zero is all zeros, maximum 0x7FFFFF.
// - Inputs beyond limits clamp the raw code to full scale before adjustment.
// - After offset and gain the result saturates to 24 bits.
// - Formats 0x1 and 0x2 append the common-mode code after 16 or 24 bits.
// - Common-mode code steps by reference over 256, clamped to 0 and 255.
// - Offset and gain touch only the difference code, never the common-mode code.
// - A signed 24-bit per-channel offset, default zero, is added.
// - A per-channel unsigned 16-bit gain over 0x8000 multiplies; default unity.
// - The output format applies to both channels alike.
module acrf_formatter #(
  parameter int CONV_CYCLES = `ACRF_CONV_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic convert_start_pin,
  input wire logic power_down,
  input wire acrf_pkg::acrf_raw_t [`ACRF_CHANNELS-1:0] held_sample,
  input wire logic [`ACRF_FMT_W-1:0] output_format_select,
  input wire logic [`ACRF_CHANNELS-1:0][`ACRF_DIFF_W-1:0] channel_offset,
  input wire logic [`ACRF_CHANNELS-1:0][`ACRF_GAIN_W-1:0] channel_gain_factor,
  output logic busy,
  output logic result_valid,
  output acrf_pkg::acrf_word_t [`ACRF_CHANNELS-1:0] result
);
  import acrf_pkg::*;

  localparam logic [`ACRF_COUNT_W-1:0] CONV_LAST = `ACRF_COUNT_W'(CONV_CYCLES - 1);

  acrf_ctl_t st;
  acrf_ctl_t next_st;
  logic start_edge;
  logic start_ok;
  logic done;
  logic [`ACRF_CHANNELS-1:0][`ACRF_DIFF_W-1:0] scaled;
  acrf_word_t [`ACRF_CHANNELS-1:0] fmt_word;

  // --------------------------------------------------------------------------
  // Conversion sequencing
  // --------------------------------------------------------------------------
  assign start_edge = convert_start_pin && !st.pin_prev;
  assign start_ok = start_edge && !power_down && (st.phase == ACRF_IDLE);
  assign done = (st.phase == ACRF_CONV) && (st.count == '0);

  always_comb begin
    next_st = st;
    next_st.pin_prev = convert_start_pin;
    unique case (st.phase)
      ACRF_IDLE: begin
        // The samples are captured on the very edge, so nothing older can leak out.
        if (start_ok) begin
          next_st.held = held_sample;
          next_st.count = CONV_LAST;
          next_st.phase = ACRF_CONV;
        end
      end
      ACRF_CONV: begin
        if (done) begin
          next_st.phase = ACRF_IDLE;
        end else begin
          next_st.count = st.count - `ACRF_COUNT_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '{phase: ACRF_IDLE, pin_prev: 1'b0, count: '0, held: '0};
    end else begin
      st <= next_st;
    end
  end

  assign busy = (st.phase == ACRF_CONV);

  // --------------------------------------------------------------------------
  // Per-channel adjustment and formatting
  // --------------------------------------------------------------------------
  for (genvar ch = 0; ch < `ACRF_CHANNELS; ch++) begin : g_chan
    acrf_scale #(
      .DW(`ACRF_DIFF_W),
      .GW(`ACRF_GAIN_W),
      .FRAC(`ACRF_GAIN_FRAC)
    ) u_scale (
      .raw_code(st.held[ch].diff),
      .over_pos(st.held[ch].over_pos),
      .over_neg(st.held[ch].over_neg),
      .offset(channel_offset[ch]),
      .gain(channel_gain_factor[ch]),
      .scaled(scaled[ch])
    );

    // One format select serves every channel.
    always_comb begin
      unique case (output_format_select)
        `ACRF_FMT_DIFF16_CM: begin
          fmt_word[ch].data = {8'h00, scaled[ch][23:8], st.held[ch].cm};
          fmt_word[ch].bits = `ACRF_BITS_24;
        end
        `ACRF_FMT_DIFF24_CM: begin
          fmt_word[ch].data = {scaled[ch], st.held[ch].cm};
          fmt_word[ch].bits = `ACRF_BITS_32;
        end
        default: begin
          fmt_word[ch].data = {8'h00, scaled[ch]};
          fmt_word[ch].bits = `ACRF_BITS_24;
        end
      endcase
    end
  end

  acrf_result_reg u_result (
    .clk(clk),
    .rst_n(rst_n),
    .load(done),
    .din(fmt_word),
    .dout(result),
    .valid(result_valid)
  );

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic [`ACRF_COUNT_W-1:0] busy_len;
  logic [`ACRF_WORD_W-1:0] exp_word;
  logic [`ACRF_DIFF_W-1:0] exp_cm_word;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_len <= '0;
    end else if (busy) begin
      busy_len <= busy_len + `ACRF_COUNT_W'(1);
    end else begin
      busy_len <= '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      exp_word <= '0;
      exp_cm_word <= '0;
    end else if (done) begin
      exp_word <= fmt_word[0].data;
      exp_cm_word <= {16'h0000, st.held[0].cm};
    end
  end

  AST_START_BUSY: assert property (start_ok |=> busy)
    else $error("Accepted convert edge did not raise busy.");
  AST_BUSY_LEN: assert property ($fell(busy) |-> busy_len == `ACRF_COUNT_W'(CONV_CYCLES))
    else $error("Busy lasted the wrong number of cycles.");
  AST_LOAD_ON_FALL: assert property ($fell(busy) |-> result_valid)
    else $error("Busy fell without a result update.");
  AST_LOAD_ONLY_FALL: assert property (result_valid |-> $fell(busy))
    else $error("Result updated while busy did not fall.");
  AST_HOLD: assert property (!result_valid |-> $stable(result))
    else $error("Output register changed between conversions.");
  AST_SAME_CONV: assert property (result_valid |-> result[0].data == exp_word)
    else $error("Result does not match the conversion just finished.");
  AST_PD_IGNORE: assert property (power_down && !busy |=> !busy)
    else $error("Conversion started during power-down.");
  AST_UNITY: assert property (done && !st.held[0].over_pos && !st.held[0].over_neg
      && channel_gain_factor[0] == `ACRF_GAIN_UNITY && channel_offset[0] == `ACRF_OFFSET_RESET
      |-> scaled[0] == st.held[0].diff)
    else $error("Default offset and gain altered the code.");
  AST_CLAMP_POS: assert property (done && st.held[0].over_pos
      && channel_gain_factor[0] == `ACRF_GAIN_UNITY && channel_offset[0] == `ACRF_OFFSET_RESET
      |-> scaled[0] == `ACRF_DIFF_MAX)
    else $error("Positive overrange was not clamped to full scale.");
  AST_SAT_RANGE: assert property (done && channel_offset[0] == `ACRF_DIFF_MAX && !st.held[0].over_neg
      && !st.held[0].diff[23] && channel_gain_factor[0] >= `ACRF_GAIN_UNITY
      |-> scaled[0] == `ACRF_DIFF_MAX)
    else $error("Large positive result did not saturate.");
  AST_CM_PASS: assert property (result_valid && $past(output_format_select) == `ACRF_FMT_DIFF24_CM
      |-> {16'h0000, result[0].data[7:0]} == exp_cm_word && result[0].bits == `ACRF_BITS_32)
    else $error("Common-mode code not appended unchanged.");
  AST_MODE0: assert property (result_valid && $past(output_format_select) == `ACRF_FMT_DIFF24
      |-> result[0].bits == `ACRF_BITS_24 && result[0].data[31:24] == 8'h00)
    else $error("Plain format carried extra bits.");

  // --------------------------------------------------------------------------
  // Further checks on the negative clamp, the short format and channel one
  // --------------------------------------------------------------------------
  // A negative or zero offset can only push a negative full-scale code further down.
  AST_CLAMP_NEG: assert property (done && st.held[0].over_neg && !st.held[0].over_pos
      && (channel_offset[0][`ACRF_DIFF_W-1] || channel_offset[0] == `ACRF_OFFSET_RESET)
      && channel_gain_factor[0] == `ACRF_GAIN_UNITY
      |-> scaled[0] == `ACRF_DIFF_MIN)
    else $error("Negative overrange was not clamped to full scale.");
  AST_CM_SHORT: assert property (result_valid && $past(output_format_select) == `ACRF_FMT_DIFF16_CM
      |-> result[0].bits == `ACRF_BITS_24 && result[0].data[31:24] == 8'h00
      && {16'h0000, result[0].data[7:0]} == exp_cm_word)
    else $error("Short format did not carry the common-mode code.");
  AST_UNITY_CH1: assert property (done && !st.held[1].over_pos && !st.held[1].over_neg
      && channel_gain_factor[1] == `ACRF_GAIN_UNITY && channel_offset[1] == `ACRF_OFFSET_RESET
      |-> scaled[1] == st.held[1].diff)
    else $error("Default offset and gain altered the second channel.");
  // Both channels share one format, so their widths always agree.
  AST_SAME_FORMAT: assert property (result_valid |-> result[1].bits == result[0].bits)
    else $error("Channels were given different formats.");

  COV_CONVERSION: cover property ($fell(busy));
  COV_CM_FORMAT: cover property (result_valid && result[0].bits == `ACRF_BITS_32);
  COV_OVERRANGE: cover property (done && st.held[0].over_neg);
  COV_EDGE_WHILE_BUSY: cover property (busy && start_edge);
endmodule // acrf_formatter

// file: verification/acrf_host.sv
// ----------------------------------------------------------------------------
// Host side of the convert link
// ----------------------------------------------------------------------------
module acrf_host (
  input wire logic clk,
  output logic convert_start_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    convert_start_pin = 1'b0;
  end

  // One rising edge per request, with a low sample before the next one.
  task automatic pulse();
    @(negedge clk);
    convert_start_pin = 1'b1;
    @(negedge clk);
    convert_start_pin = 1'b0;
  endtask
endmodule // acrf_host

// file: verification/acrf_formatter_tb.sv
`include "acrf_defines.svh"

module acrf_formatter_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import acrf_pkg::*;

  localparam int CONV = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic power_down = 1'b0;
  logic convert_start_pin;
  acrf_raw_t [1:0] held_sample;
  logic [2:0] fmt;
  logic [1:0][23:0] offs;
  logic [1:0][15:0] gains;
  logic busy;
  logic result_valid;
  acrf_word_t [1:0] result;
  acrf_word_t [1:0] last;
  acrf_word_t [1:0] expq[$];
  int fail_count = 0;
  int num_checks = 0;

  always #50 clk = ~clk;

  acrf_host host_u (
    .clk(clk),
    .convert_start_pin(convert_start_pin)
  );

  acrf_formatter #(.CONV_CYCLES(CONV)) dut_u (
    .clk(clk),
    .rst_n(rst_n),
    .convert_start_pin(convert_start_pin),
    .power_down(power_down),
    .held_sample(held_sample),
    .output_format_select(fmt),
    .channel_offset(offs),
    .channel_gain_factor(gains),
    .busy(busy),
    .result_valid(result_valid),
    .result(result)
  );

  // ----------------------------------------------------------------------------
  // Reference model of the processing chain
  // ----------------------------------------------------------------------------
  function automatic acrf_word_t model(acrf_raw_t r, logic [2:0] f, logic [23:0] off, logic [15:0] g);
    logic signed [47:0] v;
    acrf_word_t w;
    v = r.over_pos ? 48'sh7fffff : r.over_neg ? -48'sh800000 : 48'($signed(r.diff));
    v = v + 48'($signed(off));
    v = (v * $signed({32'h0, g})) >>> 15;
    if (v > 48'sh7fffff) begin
      v = 48'sh7fffff;
    end else if (v < -48'sh800000) begin
      v = -48'sh800000;
    end
    case (f)
      3'h1: w = '{data: {8'h00, v[23:8], r.cm}, bits: 6'h18};
      3'h2: w = '{data: {v[23:0], r.cm}, bits: 6'h20};
      default: w = '{data: {8'h00, v[23:0]}, bits: 6'h18};
    endcase
    return w;
  endfunction

  task automatic chk(input logic [75:0] got, input logic [75:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------------------
  always @(negedge clk) begin
    if (rst_n && result_valid === 1'b1) begin
      if (expq.size() == 0) begin
        chk(76'(result), ~76'(result));
      end else begin
        last = expq.pop_front();
        chk(result, last);
      end
    end
  end

  // Runs one conversion; dbl adds a start edge while busy, pd tries it in power-down.
  task automatic conv(input bit dbl, input bit pd);
    int n;
    n = 0;
    @(negedge clk);
    power_down = pd;
    if (!pd) begin
      expq.push_back({model(held_sample[1], fmt, offs[1], gains[1]), model(held_sample[0], fmt, offs[0], gains[0])});
    end
    host_u.pulse();
    if (dbl) begin
      host_u.pulse();
    end
    for (int i = 0; i < 50 && busy === 1'b1; i++) begin
      n++;
      @(negedge clk);
    end
    chk(76'(n), pd ? 76'd0 : dbl ? 76'(CONV - 2) : 76'(CONV));
    repeat (2) @(negedge clk);
    power_down = 1'b0;
  endtask

  task automatic rnd();
    for (int c = 0; c < 2; c++) begin
      held_sample[c] = '{over_pos: 1'b0, over_neg: 1'b0, diff: 24'($urandom), cm: 8'($urandom)};
      offs[c] = 24'($urandom);
      gains[c] = 16'($urandom);
    end
  endtask

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    acrf_raw_t sat[3];
    logic [23:0] sat_off[3];
    logic [15:0] sat_gain[3];
    logic [2:0] fmts[4];
    fmts = '{3'h0, 3'h1, 3'h2, 3'h7};
    held_sample = '0;
    fmt = 3'h0;
    offs = '0;
    gains = {16'h8000, 16'h8000};
    void'($urandom(32'h89943c43));
    repeat (3) @(negedge clk);
    chk(76'({busy, result_valid, result}), 76'h0);
    rst_n = 1'b1;
    held_sample[0] = '{over_pos: 1'b0, over_neg: 1'b0, diff: 24'h000000, cm: 8'h80};
    held_sample[1] = '{over_pos: 1'b0, over_neg: 1'b0, diff: 24'hffffff, cm: 8'hff};
    conv(1'b0, 1'b0);
    $display("test 1 done: first conversion");
    foreach (fmts[k]) begin
      fmt = fmts[k];
      repeat (4) begin
        rnd();
        conv(1'b0, 1'b0);
      end
    end
    $display("test 2 done: formats");
    sat = '{'{1'b1, 1'b0, 24'h123456, 8'h00}, '{1'b0, 1'b1, 24'h000001, 8'hff}, '{1'b1, 1'b1, 24'h7fffff, 8'h01}};
    sat_off = '{24'h000001, 24'hffffff, 24'h7fffff};
    sat_gain = '{16'h8000, 16'h8000, 16'hffff};
    for (int k = 0; k < 3; k++) begin
      held_sample = {sat[k], sat[2 - k]};
      offs = {sat_off[k], sat_off[2 - k]};
      gains = {sat_gain[k], sat_gain[2 - k]};
      conv(1'b0, 1'b0);
    end
    $display("test 3 done: saturation");
    rnd();
    conv(1'b1, 1'b0);
    rnd();
    conv(1'b0, 1'b1);
    chk(result, last);
    conv(1'b0, 1'b0);
    $display("test 4 done: refused edges and power-down");
    repeat (3) @(negedge clk);
    chk(76'(expq.size()), 76'd0);
    stop_test();
  end
endmodule // acrf_formatter_tb
